// ==== aeoi_pkg.sv ====
// Shared constants for the converter encode/output link.
// Assumes a 200 MHz system clock shared by both ends.
package aeoi_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CODE_W     = 12;
  localparam int UV_W       = 24;
  localparam int SENSE_W    = 21;
  localparam int PROD_W     = 40;
  localparam int SYNC_W     = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS     = 5000;
  localparam int PS_PER_US         = 1000000;
  localparam int PS_PER_NS         = 1000;
  localparam int ENC_RATE_MAX_MSPS = 80;
  localparam int ENC_RATE_MIN_MSPS = 1;
  localparam int ENC_HALF_MIN_NS   = 6;
  localparam int ENC_DUTY_PCT      = 50;
  localparam int ENC_DUTY_TOL_PCT  = 4;
  // Shortest period, rounded up
  localparam int ENC_PERIOD_MIN_CYC =
    (PS_PER_US / ENC_RATE_MAX_MSPS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ENC_HALF_NS_CYC =
    (ENC_HALF_MIN_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ENC_HALF_RATE_CYC = (ENC_PERIOD_MIN_CYC + 1) / 2;
  localparam int ENC_HALF_MIN_CYC  =
    (ENC_HALF_NS_CYC > ENC_HALF_RATE_CYC) ? ENC_HALF_NS_CYC
                                          : ENC_HALF_RATE_CYC;
  // Longest period, rounded down
  localparam int ENC_PERIOD_MAX_CYC =
    (PS_PER_US / ENC_RATE_MIN_MSPS) / CLK_PERIOD_PS;
  localparam int ENC_HALF_MAX_CYC = ENC_PERIOD_MAX_CYC / 2;

  // ----------------------------------------------------------------
  // Input span, microvolts peak-to-peak
  // ----------------------------------------------------------------
  localparam logic [SENSE_W:0] SPAN_G0_HIGH_UV = 22'd2250000;
  localparam logic [SENSE_W:0] SPAN_G1_HIGH_UV = 22'd1350000;
  localparam logic [SENSE_W:0] SPAN_G0_LOW_UV  = 22'd1400000;
  localparam logic [SENSE_W:0] SPAN_G1_LOW_UV  = 22'd840000;
  localparam int SPAN_G1_MUL = 6;
  localparam int SPAN_G1_DIV = 5;

  typedef enum logic [1:0] {
    AEOI_STRAP_GND = 2'b00,
    AEOI_STRAP_VDD = 2'b01,
    AEOI_STRAP_MID = 2'b10
  } aeoi_strap_t;

  localparam logic [CODE_W-1:0] CODE_MAX = 12'hFFF;
  localparam logic [CODE_W-1:0] CODE_MIN = 12'h000;

  // ----------------------------------------------------------------
  // Host register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 5'h00;
  localparam logic [ADDR_W-1:0] REG_HALF   = 5'h04;
  localparam logic [ADDR_W-1:0] REG_DATA   = 5'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_ST = 5'h0C;
  localparam logic [ADDR_W-1:0] REG_IRQ_MK = 5'h10;

  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_FMT_BIT  = 1;
  localparam int CTRL_GAIN_BIT = 2;
  localparam int DATA_OF_BIT   = 12;
  localparam int IRQ_W         = 2;
  localparam int IRQ_SAMPLE    = 0;
  localparam int IRQ_OVER      = 1;
  localparam int HALF_W        = 8;

  localparam logic [2:0]        CTRL_RST = 3'h0;
  localparam logic [HALF_W-1:0] HALF_RST = 8'h05;

endpackage : aeoi_pkg

// ==== aeoi_link_if.sv ====
// Pin-level link between the converter end and the capture host.
// Both ends run on the shared mclk_i; every pin here is a plain level.
interface aeoi_link_if;
  import aeoi_pkg::*;

  logic              encode_clock;
  logic              format_select;
  logic              gain_select;
  logic              data_ready_clock;
  logic [CODE_W-1:0] data;
  logic              overrange_flag;

  modport dev (
    input  encode_clock,
    input  format_select,
    input  gain_select,
    output data_ready_clock,
    output data,
    output overrange_flag
  );

  modport host (
    output encode_clock,
    output format_select,
    output gain_select,
    input  data_ready_clock,
    input  data,
    input  overrange_flag
  );

endinterface : aeoi_link_if

// ==== aeoi_conv.sv ====
// Digital side of a 12-bit pipelined sampling converter.
// Assumes the encode clock arrives from another domain and is far
// slower than mclk_i; analog input is given in microvolts.
//
// Notes on behaviour
// R1: Encode rate never above 80 Msps.
// R2: At full rate, duty cycle 50 +/- 4 percent.
// R3: Each encode half lasts at least 6 ns.
// R4: Encode rate never below 1 Msps; the host stops the encode clock while the CTRL enable bit is low.
// R5: Track while low, hold at rising edge.
// R6: Span from gain select and reference strap.
// R7: Format high offset binary, low two's complement.
// R8: Overrange flag high when sample out of span.
// R9: Data-ready clock is delayed encode clock copy.
// R10: Data and flag change after data-ready falls.
// R11: Host captures on data-ready rising edge.
// R12: Host times capture from data-ready, not encode.
// R13: 12-bit word plus flag, fixed pipeline latency.
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.
module aeoi_conv
  import aeoi_pkg::*;
#(
  parameter int PIPE_DEPTH = 5,
  parameter int DRC_DELAY  = 2
) (
  input  wire logic                      mclk_i,
  input  wire logic                      reset_i,
  input  wire logic signed [UV_W-1:0]    analog_uv_i,
  input  wire logic        [1:0]         ref_strap_i,
  input  wire logic        [SENSE_W-1:0] sense_uv_i,
  aeoi_link_if.dev                       link
);

  // ----------------------------------------------------------------
  // Encode clock synchroniser
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] enc_sync_r;
  logic              enc_lvl_r;
  logic              enc_rise;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      enc_sync_r <= '0;
    end else begin
      enc_sync_r <= {enc_sync_r[SYNC_W-2:0], link.encode_clock};
    end
  end

  // Only stages two and three decide a change
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      enc_lvl_r <= 1'b0;
    end else if (enc_sync_r[1] == enc_sync_r[2]) begin
      enc_lvl_r <= enc_sync_r[2];
    end
  end

  assign enc_rise = (enc_sync_r[1] == enc_sync_r[2]) && enc_sync_r[2]
                    && !enc_lvl_r;

  // ----------------------------------------------------------------
  // Strap synchronisers
  // ----------------------------------------------------------------
  // Straps come from the host's domain; a setting that moves while a
  // word is formed settles here before it reaches the datapath
  logic [SYNC_W-1:0] fmt_sync_r;
  logic [SYNC_W-1:0] gain_sync_r;
  logic              fmt_lvl_r;
  logic              gain_lvl_r;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      fmt_sync_r  <= '0;
      gain_sync_r <= '0;
    end else begin
      fmt_sync_r  <= {fmt_sync_r[SYNC_W-2:0], link.format_select};
      gain_sync_r <= {gain_sync_r[SYNC_W-2:0], link.gain_select};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      fmt_lvl_r  <= 1'b0;
      gain_lvl_r <= 1'b0;
    end else begin
      if (fmt_sync_r[1] == fmt_sync_r[2]) begin
        fmt_lvl_r <= fmt_sync_r[2];
      end
      if (gain_sync_r[1] == gain_sync_r[2]) begin
        gain_lvl_r <= gain_sync_r[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Input span and conversion
  // ----------------------------------------------------------------
  logic        [SENSE_W:0] span_uv;
  logic signed [PROD_W-1:0] half_uv;
  logic signed [PROD_W-1:0] shifted_uv;
  logic signed [PROD_W-1:0] scaled;
  logic        [CODE_W-1:0] conv_code;
  logic                     conv_over;

  always_comb begin
    span_uv = SPAN_G0_HIGH_UV;
    unique case (aeoi_strap_t'(ref_strap_i))
      AEOI_STRAP_VDD: span_uv = gain_lvl_r ? SPAN_G1_HIGH_UV
                                           : SPAN_G0_HIGH_UV; // R6
      AEOI_STRAP_GND: span_uv = gain_lvl_r ? SPAN_G1_LOW_UV
                                           : SPAN_G0_LOW_UV; // R6
      AEOI_STRAP_MID: begin
        if (gain_lvl_r) begin
          span_uv = (SENSE_W+1)'((PROD_W)'(sense_uv_i) * SPAN_G1_MUL
                                 / SPAN_G1_DIV); // R6
        end else begin
          span_uv = {sense_uv_i, 1'b0}; // R6
        end
      end
      // Both strap bits high reads as tied high
      default: span_uv = gain_lvl_r ? SPAN_G1_HIGH_UV
                                    : SPAN_G0_HIGH_UV; // R6
    endcase
  end

  // Clamp to end codes; divisor is span_uv, fixed per strap and gain, from sense_uv_i at the mid strap
  always_comb begin
    half_uv    = signed'((PROD_W)'(span_uv >> 1));
    shifted_uv = (PROD_W)'(analog_uv_i) + half_uv;
    scaled     = '0;
    conv_code  = CODE_MIN;
    conv_over  = 1'b0;
    if (shifted_uv < 0) begin
      conv_over = 1'b1; // R8
      conv_code = CODE_MIN;
    end else if (shifted_uv >= signed'((PROD_W)'(span_uv))) begin
      conv_over = 1'b1; // R8
      conv_code = CODE_MAX;
    end else if (span_uv != '0) begin
      scaled    = (shifted_uv <<< CODE_W) / signed'((PROD_W)'(span_uv));
      conv_code = scaled[CODE_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Sample pipeline
  // ----------------------------------------------------------------
  logic [CODE_W:0] pipe_r [PIPE_DEPTH];

  // Held sample enters at each rising encode edge
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pipe_r[0] <= '0;
    end else if (enc_rise) begin
      pipe_r[0] <= {conv_over, conv_code}; // R5
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < PIPE_DEPTH; gi++) begin : g_pipe
      always_ff @(posedge mclk_i) begin
        if (reset_i) begin
          pipe_r[gi] <= '0;
        end else if (enc_rise) begin
          pipe_r[gi] <= pipe_r[gi-1]; // R13
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Data-ready clock and output word
  // ----------------------------------------------------------------
  logic [DRC_DELAY-1:0] drc_dly_r;
  logic                 drc_r;
  logic [CODE_W-1:0]    data_r;
  logic                 over_r;
  logic                 drc_fall;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      drc_dly_r <= '0;
      drc_r     <= 1'b0;
    end else begin
      drc_dly_r <= {drc_dly_r[DRC_DELAY-2:0], enc_lvl_r}; // R9
      drc_r     <= drc_dly_r[DRC_DELAY-1]; // R9
    end
  end

  assign drc_fall = drc_r && !drc_dly_r[DRC_DELAY-1];

  // Word moves on the edge that drops data-ready, so it is
  // stable across the whole high half that follows
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      data_r <= '0;
      over_r <= 1'b0;
    end else if (drc_fall) begin
      data_r <= {pipe_r[PIPE_DEPTH-1][CODE_W-1] ^ ~fmt_lvl_r,
                 pipe_r[PIPE_DEPTH-1][CODE_W-2:0]}; // R7 R10 R13
      over_r <= pipe_r[PIPE_DEPTH-1][CODE_W]; // R8 R10
    end
  end

  assign link.data_ready_clock = drc_r;
  assign link.data             = data_r;
  assign link.overrange_flag   = over_r;

endmodule : aeoi_conv

// ==== aeoi_host.sv ====
// Capture host: makes the encode clock, drives the straps, and
// catches each word on the data-ready rising edge.
// Assumes an Avalon-MM master with waitrequest on the software side.
module aeoi_host
  import aeoi_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  output logic                   irq_o,
  output logic      [CODE_W-1:0] sample_o,
  output logic                   sample_over_o,
  output logic                   sample_valid_o,
  aeoi_link_if.host              link
);

  // ----------------------------------------------------------------
  // Avalon slave, one wait state per access
  // ----------------------------------------------------------------
  logic [2:0]        ctrl_r;
  logic [HALF_W-1:0] half_r;
  logic [CODE_W:0]   last_r;
  logic [IRQ_W-1:0]  irq_st_r;
  logic [IRQ_W-1:0]  irq_mk_r;
  logic [IRQ_W-1:0]  irq_evt;
  logic              wait_r;
  logic [31:0]       rdata_r;
  logic              acc_go;
  logic              wr_go;

  assign acc_go = (avs_read_i || avs_write_i) && !wait_r;
  assign wr_go  = avs_write_i && !wait_r;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !((avs_read_i || avs_write_i) && wait_r);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_r <= '0;
    end else if (avs_read_i && wait_r) begin
      case (avs_address_i)
        REG_CTRL:   rdata_r <= 32'(ctrl_r);
        REG_HALF:   rdata_r <= 32'(half_r);
        REG_DATA:   rdata_r <= 32'(last_r);
        REG_IRQ_ST: rdata_r <= 32'(irq_st_r);
        REG_IRQ_MK: rdata_r <= 32'(irq_mk_r);
        default:    rdata_r <= '0;
      endcase
    end
  end

  // Out-of-range half periods are clamped, never stored
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_r   <= CTRL_RST;
      half_r   <= HALF_RST;
      irq_mk_r <= '0;
    end else if (wr_go) begin
      if (avs_address_i == REG_CTRL) begin
        ctrl_r <= avs_writedata_i[2:0];
      end
      if (avs_address_i == REG_HALF) begin
        if (avs_writedata_i < 32'(ENC_HALF_MIN_CYC)) begin
          half_r <= HALF_W'(ENC_HALF_MIN_CYC); // R1 R2 R3
        end else if (avs_writedata_i > 32'(ENC_HALF_MAX_CYC)) begin
          half_r <= HALF_W'(ENC_HALF_MAX_CYC); // R4
        end else begin
          half_r <= avs_writedata_i[HALF_W-1:0];
        end
      end
      if (avs_address_i == REG_IRQ_MK) begin
        irq_mk_r <= avs_writedata_i[IRQ_W-1:0];
      end
    end
  end

  // New events win over a same-cycle write-one clear
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      irq_st_r <= '0;
    end else if (wr_go && avs_address_i == REG_IRQ_ST) begin
      irq_st_r <= (irq_st_r & ~avs_writedata_i[IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_st_r <= irq_st_r | irq_evt;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_st_r & irq_mk_r);
    end
  end

  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o    = rdata_r;

  // ----------------------------------------------------------------
  // Encode clock divider, equal halves
  // ----------------------------------------------------------------
  logic [HALF_W-1:0] div_cnt_r;
  logic              enc_r;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      div_cnt_r <= '0;
      enc_r     <= 1'b0;
    end else if (!ctrl_r[CTRL_EN_BIT] && !enc_r) begin
      // Stops only once low, so a disable never cuts a high half
      div_cnt_r <= '0; // R3
    end else if (div_cnt_r >= half_r - 1'b1) begin
      div_cnt_r <= '0;
      enc_r     <= ~enc_r; // R2 R3
    end else begin
      div_cnt_r <= div_cnt_r + 1'b1;
    end
  end

  assign link.encode_clock  = enc_r;
  assign link.format_select = ctrl_r[CTRL_FMT_BIT];
  assign link.gain_select   = ctrl_r[CTRL_GAIN_BIT];

  // ----------------------------------------------------------------
  // Capture on data-ready rising edge
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] drc_sync_r;
  logic              drc_lvl_r;
  logic              drc_rise;
  // Word rides the same stages as data-ready, so the copy taken at
  // the seen rise is the one that stood at the pin edge
  logic [SYNC_W-1:0][CODE_W:0] word_sync_r;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      drc_sync_r  <= '0;
      drc_lvl_r   <= 1'b0;
      word_sync_r <= '0;
    end else begin
      drc_sync_r  <= {drc_sync_r[SYNC_W-2:0], link.data_ready_clock};
      word_sync_r <= {word_sync_r[SYNC_W-2:0],
                      link.overrange_flag, link.data};
      if (drc_sync_r[1] == drc_sync_r[2]) begin
        drc_lvl_r <= drc_sync_r[2];
      end
    end
  end

  assign drc_rise = (drc_sync_r[1] == drc_sync_r[2]) && drc_sync_r[2]
                    && !drc_lvl_r; // R12

  assign irq_evt = {drc_rise && word_sync_r[SYNC_W-1][CODE_W], drc_rise};

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      last_r         <= '0;
      sample_o       <= '0;
      sample_over_o  <= 1'b0;
      sample_valid_o <= 1'b0;
    end else begin
      sample_valid_o <= drc_rise;
      if (drc_rise) begin
        last_r        <= word_sync_r[SYNC_W-1]; // R11
        sample_o      <= word_sync_r[SYNC_W-1][CODE_W-1:0]; // R11
        sample_over_o <= word_sync_r[SYNC_W-1][CODE_W]; // R11
      end
    end
  end

endmodule : aeoi_host

// ==== aeoi_link_props.sv ====
// Link checker: pin-level relations between converter end and host.
// Assumes both ends share mclk_i and the synchronous reset.
module aeoi_link_props
  import aeoi_pkg::*;
(
  input wire logic              mclk_i,
  input wire logic              reset_i,
  input wire logic              encode_clock,
  input wire logic              format_select,
  input wire logic              gain_select,
  input wire logic              data_ready_clock,
  input wire logic [CODE_W-1:0] data,
  input wire logic              overrange_flag
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Encode half-period measurement
  // ----------------------------------------------------------------
  logic        enc_d_r;
  logic [17:0] run_r;
  logic [17:0] last_r;
  logic        enc_chg;

  assign enc_chg = encode_clock != enc_d_r;

  // Saturates so a long stop cannot wrap into a short half
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      enc_d_r <= 1'h0;
      run_r   <= 18'h00000;
      last_r  <= 18'h00000;
    end else begin
      enc_d_r <= encode_clock;
      if (enc_chg) begin
        run_r  <= 18'h00001;
        last_r <= run_r;
      end else if (run_r != 18'h3FFFF) begin
        run_r <= run_r + 18'h00001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  sequence s_enc_up;  $rose(encode_clock);                  endsequence
  sequence s_drc_up;  ##[4:8] $rose(data_ready_clock);      endsequence
  sequence s_enc_dn;  $fell(encode_clock);                  endsequence
  sequence s_drc_dn;  ##[4:8] $fell(data_ready_clock);      endsequence

  property p_drc_rise; s_enc_up |-> s_drc_up; endproperty
  property p_drc_fall; s_enc_dn |-> s_drc_dn; endproperty
  property p_drc_idle;
    !encode_clock [*8] |-> !data_ready_clock;
  endproperty
  property p_data_at_fall;
    !$stable(data) |-> $fell(data_ready_clock);
  endproperty
  property p_flag_at_fall;
    !$stable(overrange_flag) |-> $fell(data_ready_clock);
  endproperty
  property p_capture;
    $rose(data_ready_clock) |-> $stable({data, overrange_flag}) [*2];
  endproperty
  property p_half_min;
    enc_chg && run_r != 18'h00000 |-> run_r >= 18'(ENC_HALF_MIN_CYC);
  endproperty
  property p_period_min;
    enc_chg && encode_clock && last_r != 18'h00000
      |-> 19'(run_r) + 19'(last_r) >= 19'(ENC_PERIOD_MIN_CYC);
  endproperty

  a_drc_rise: assert property (p_drc_rise)
    else $error("data-ready rise not within 4..8 cycles of encode rise");
  a_drc_fall: assert property (p_drc_fall)
    else $error("data-ready fall not within 4..8 cycles of encode fall");
  a_drc_idle: assert property (p_drc_idle)
    else $error("data-ready high while encode stopped low");
  a_data_at_fall: assert property (p_data_at_fall)
    else $error("data word changed away from data-ready fall");
  a_flag_at_fall: assert property (p_flag_at_fall)
    else $error("overrange flag changed away from data-ready fall");
  a_capture: assert property (p_capture)
    else $error("word moved around data-ready rise");
  a_half_min: assert property (p_half_min)
    else $error("encode half shorter than minimum");
  a_period_min: assert property (p_period_min)
    else $error("encode period shorter than minimum");

endmodule : aeoi_link_props

// ==== tb_adc_encode_and_output_interface.sv ====
// Bench: converter end and capture host joined by the link interface.
// Assumes the host register map and span constants of the package.
module tb_adc_encode_and_output_interface
  import aeoi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic               fmt;
    logic               gain;
    logic [1:0]         strap;
    logic [SENSE_W-1:0] sense;
    logic [UV_W-1:0]    uv;
    logic [CODE_W-1:0]  code;
    logic               ovr;
  } aeoi_row_t;

  // Midscale, quarter points and span edges on both sides, every strap and format
  aeoi_row_t rows [10] = '{
    '{1'h1, 1'h0, 2'h1, 21'h000000, 24'h000000, 12'h800, 1'h0},
    '{1'h0, 1'h0, 2'h1, 21'h000000, 24'h000000, 12'h000, 1'h0},
    '{1'h1, 1'h0, 2'h3, 21'h000000, 24'hEED578, 12'h000, 1'h0},
    '{1'h1, 1'h0, 2'h1, 21'h000000, 24'h112A87, 12'hFFF, 1'h0},
    '{1'h1, 1'h0, 2'h0, 21'h000000, 24'hF3CB00, 12'h000, 1'h1},
    '{1'h0, 1'h1, 2'h0, 21'h000000, 24'h033450, 12'h400, 1'h0},
    '{1'h1, 1'h0, 2'h2, 21'h0F4240, 24'hF85EE0, 12'h400, 1'h0},
    '{1'h1, 1'h1, 2'h2, 21'h0F4240, 24'h0493E0, 12'hC00, 1'h0},
    '{1'h0, 1'h0, 2'h1, 21'h000000, 24'h112A88, 12'h7FF, 1'h1},
    '{1'h1, 1'h1, 2'h1, 21'h000000, 24'h0A4CB8, 12'hFFF, 1'h1}};

  logic               mclk_i;
  logic               reset_i;
  logic [UV_W-1:0]    analog_uv;
  logic [1:0]         ref_strap;
  logic [SENSE_W-1:0] sense_uv;
  logic [ADDR_W-1:0]  avs_address;
  logic               avs_read;
  logic               avs_write;
  logic [31:0]        avs_wdata;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic               irq;
  logic [CODE_W-1:0]  sample;
  logic               sample_over;
  logic               sample_valid;
  logic [31:0]        rd;
  int                 error_cnt = 0;
  int                 num_checks = 0;

  aeoi_link_if aeoi_link_if_inst ();

  aeoi_conv #(.PIPE_DEPTH(5), .DRC_DELAY(2)) aeoi_conv_inst (
    .mclk_i(mclk_i), .reset_i(reset_i), .analog_uv_i(analog_uv),
    .ref_strap_i(ref_strap), .sense_uv_i(sense_uv),
    .link(aeoi_link_if_inst));

  aeoi_host aeoi_host_inst (
    .mclk_i(mclk_i), .reset_i(reset_i), .avs_address_i(avs_address),
    .avs_read_i(avs_read), .avs_write_i(avs_write),
    .avs_writedata_i(avs_wdata), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest), .irq_o(irq),
    .sample_o(sample), .sample_over_o(sample_over),
    .sample_valid_o(sample_valid), .link(aeoi_link_if_inst));

  aeoi_link_props aeoi_link_props_inst (
    .mclk_i(mclk_i), .reset_i(reset_i),
    .encode_clock(aeoi_link_if_inst.encode_clock),
    .format_select(aeoi_link_if_inst.format_select),
    .gain_select(aeoi_link_if_inst.gain_select),
    .data_ready_clock(aeoi_link_if_inst.data_ready_clock),
    .data(aeoi_link_if_inst.data),
    .overrange_flag(aeoi_link_if_inst.overrange_flag));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    @(posedge mclk_i);
    avs_address <= a;
    avs_read    <= ~w;
    avs_write   <= w;
    avs_wdata   <= d;
    do begin
      @(posedge mclk_i);
    end while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
  endtask : bus

  task automatic wait_smp(input int n);
    while (n > 0) begin
      @(negedge mclk_i);
      if (sample_valid === 1'h1) n--;
    end
  endtask : wait_smp

  // ----------------------------------------------------------------
  // Clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    mclk_i = 1'h0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  // Whole run is near 600 cycles
  initial begin
    repeat (30000) @(posedge mclk_i);
    error_cnt++;
    $display("BAD watchdog exp done got timeout");
    end_of_test();
  end

  initial begin
    reset_i = 1'h1;
    analog_uv = 24'h000000;
    ref_strap = 2'h1;
    sense_uv = 21'h000000;
    avs_address = 5'h00;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_wdata = 32'h00000000;
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'h0;
    bus(1'h1, REG_HALF, 32'h00000002);
    bus(1'h1, REG_IRQ_MK, 32'h00000003);
    foreach (rows[i]) begin
      bus(1'h1, REG_CTRL, {29'h0, rows[i].gain, rows[i].fmt, 1'h1});
      analog_uv <= rows[i].uv;
      ref_strap <= rows[i].strap;
      sense_uv  <= rows[i].sense;
      wait_smp(10);
      chk("sample", {20'h0, rows[i].code}, {20'h0, sample});
      chk("over", {31'h0, rows[i].ovr}, {31'h0, sample_over});
      chk("pin_data", {20'h0, rows[i].code},
          {20'h0, aeoi_link_if_inst.data});
      chk("pin_over", {31'h0, rows[i].ovr},
          {31'h0, aeoi_link_if_inst.overrange_flag});
      bus(1'h0, REG_DATA, 32'h00000000);
      chk("data_reg", {19'h0, rows[i].ovr, rows[i].code}, rd);
      $display("row %0d done", i);
    end
    bus(1'h0, REG_IRQ_ST, 32'h00000000);
    chk("irq_status", 32'h00000003, rd);
    chk("irq_raised", 32'h00000001, {31'h0, irq});
    bus(1'h1, REG_IRQ_MK, 32'h00000000);
    repeat (2) @(negedge mclk_i);
    chk("irq_masked", 32'h00000000, {31'h0, irq});
    bus(1'h1, REG_CTRL, 32'h00000000);
    repeat (40) @(negedge mclk_i);
    chk("drc_idle", 32'h00000000,
        {31'h0, aeoi_link_if_inst.data_ready_clock});
    bus(1'h1, REG_IRQ_ST, 32'h00000003);
    bus(1'h1, REG_IRQ_MK, 32'h00000003);
    bus(1'h0, REG_IRQ_ST, 32'h00000000);
    chk("irq_cleared", 32'h00000000, rd);
    chk("irq_low", 32'h00000000, {31'h0, irq});
    $display("irq test done");
    bus(1'h1, REG_HALF, 32'h00000001);
    bus(1'h0, REG_HALF, 32'h00000000);
    chk("half_floor", 32'h00000002, rd);
    bus(1'h1, REG_HALF, 32'h000000C8);
    bus(1'h0, REG_HALF, 32'h00000000);
    chk("half_ceiling", 32'h00000064, rd);
    bus(1'h1, 5'h14, 32'hFFFFFFFF);
    bus(1'h0, 5'h14, 32'h00000000);
    chk("unmapped", 32'h00000000, rd);
    bus(1'h0, REG_CTRL, 32'h00000000);
    chk("ctrl_kept", 32'h00000000, rd);
    $display("register test done");
    bus(1'h1, REG_HALF, 32'h00000002);
    bus(1'h1, REG_CTRL, 32'h00000001);
    wait_smp(3);
    @(posedge mclk_i);
    reset_i <= 1'h1;
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'h0;
    @(negedge mclk_i);
    chk("rst_wait", 32'h00000001, {31'h0, avs_waitrequest});
    chk("rst_sample", 32'h00000000, {19'h0, sample_over, sample});
    chk("rst_enc", 32'h00000000, {31'h0, aeoi_link_if_inst.encode_clock});
    bus(1'h0, REG_CTRL, 32'h00000000);
    chk("rst_ctrl", {29'h0, CTRL_RST}, rd);
    bus(1'h0, REG_HALF, 32'h00000000);
    chk("rst_half", {24'h0, HALF_RST}, rd);
    $display("reset test done");
    end_of_test();
  end

endmodule : tb_adc_encode_and_output_interface
